// File: tx_wport_pkg.sv
// Shared constants for the transmit partition buffer and its fabric writer.
// Assumes one 50 MHz clock drives both ends and the bench that joins them.
`default_nettype none

package tx_wport_pkg;

	// ********************************************
	// Buffer geometry
	// ********************************************
	localparam int NUM_BANKS = 4;
	localparam int LANES     = 4;
	localparam int LANE_W    = 32;
	localparam int LINE_W    = LANES * LANE_W;
	localparam int ADDR_W    = 3;
	localparam int NPART     = 8;
	localparam int BV_W      = 16;
	localparam int TAG_W     = 8;
	localparam int PORT_W    = 2;
	localparam int LINE_DEPTH = 16;

	// ********************************************
	// Bank modes
	// ********************************************
	typedef enum logic [1:0] {AGG_32, AGG_64, AGG_128} agg_mode_t;
	// Partition count codes for 1, 2, 4 and 8 virtual FIFOs
	localparam logic [1:0] PART_1 = 2'h0;
	localparam logic [1:0] PART_2 = 2'h1;
	localparam logic [1:0] PART_4 = 2'h2;
	localparam logic [1:0] PART_8 = 2'h3;

	// ********************************************
	// Port poller timing, in clock cycles
	// ********************************************
	localparam int BURST_CYCLES = 4;
	localparam int SKIP_IDLE    = 2;

	// ********************************************
	// Writer register map (AXI4-Lite byte offsets)
	// ********************************************
	localparam logic [7:0] OFS_DATA0   = 8'h00;
	localparam logic [7:0] OFS_CMD     = 8'h10;
	localparam logic [7:0] OFS_INHIBIT = 8'h14;
	localparam logic [7:0] OFS_STATUS  = 8'h18;
	localparam int CMD_BV_LSB   = 0;
	localparam int CMD_TAG_LSB  = 16;
	localparam int CMD_ADDR_LSB = 24;
	localparam int CMD_SOP_BIT  = 27;
	localparam int CMD_EOP_BIT  = 28;
	localparam int CMD_BANK_LSB = 29;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// File: tx_write_if.sv
// Fabric write port between the writer and the partition buffer.
// Assumes both ends run on the same clock; the bench connects the instances.
`default_nettype none

interface tx_write_if;
	import tx_wport_pkg::*;

	// ********************************************
	// Per-bank write lanes and returned fill flag
	// ********************************************
	logic [NUM_BANKS-1:0] we;
	logic [ADDR_W-1:0]    addr [NUM_BANKS];
	logic [LANE_W-1:0]    data [NUM_BANKS];
	logic [BV_W-1:0]      byte_lane_valid [NUM_BANKS];
	logic [NUM_BANKS-1:0] sop;
	logic [NUM_BANKS-1:0] eop;
	logic [TAG_W-1:0]     logical_port_tag [NUM_BANKS];
	logic [NUM_BANKS-1:0] bank_service_inhibit;
	wire  [NUM_BANKS-1:0] full;

	modport writer (output we, addr, data, byte_lane_valid, sop, eop, logical_port_tag,
		bank_service_inhibit, input full);
	modport buffer (input we, addr, data, byte_lane_valid, sop, eop, logical_port_tag,
		bank_service_inhibit, output full);

endinterface

`default_nettype wire

// File: tx_partition_buffer.sv
// Transmit partition buffer: four banks of virtual FIFOs written by fabric logic,
// drained line by line by a calendar port poller.
// Assumes the writer shares i_clk and keeps bank settings consistent across pairs.
//
// How it works
// - Write enable plus 3-bit address stores data
// - Addressed partition fill flag returned combinationally
// - Full flag means 3/4 or full per threshold
// - Four banks, each own lane and enable
// - Per-bank 32, 64 or 128-bit aggregation
// - Per-bank split into 1, 2, 4, 8 FIFOs
// - 64-bit pairs configured alike, lead bank even
// - 128-bit: all banks alike, bank 0 leads
// - Software keeps pair modes matched
// - Low address codes decode by partition count
// - Codes 100-111 only with eight partitions, or with one, where the address is ignored
// - Lines become visible only when whole
// - Pointer advances after 4, 2 or 1 writes, or EOP
// - Writer fills complete lines
// - Write with no byte lane valid dropped
// - Inhibited bank gets no service
// - Inhibited writes accepted until partition full
// - Released bank rejoins calendar order
// - Poll lasts burst cycles, tag shows port
// - Skipping port adds two idle cycles
// - EOP closes line and advances pointer
// - Writer puts SOP in first lane
// - Port tag valid on line's last write
`default_nettype none

module tx_partition_buffer
	import tx_wport_pkg::*;
#(
	parameter int DEPTH = LINE_DEPTH,   // Lines per bank, power of two, at least 8
	parameter int BURST = BURST_CYCLES  // Poll length of every calendar port
) (
	input  wire logic              i_clk,                   // System clock
	input  wire logic              i_rst_b,                 // Async reset, active low
	tx_write_if.buffer             wr,                      // Fabric write port
	input  wire agg_mode_t         i_agg_mode [NUM_BANKS],  // Aggregation per bank
	input  wire logic [1:0]        i_part_code [NUM_BANKS], // Partition count code per bank
	input  wire logic [NUM_BANKS-1:0] i_thresh_3q,          // Full flag at 3/4 when high
	output logic [PORT_W-1:0]      o_port_tag,              // Port being polled
	output logic                   o_line_valid,            // One line read this cycle
	output logic [LINE_W-1:0]      o_line_data,             // Line data, lane 0 low
	output logic                   o_line_sop,              // Line opens a packet
	output logic                   o_line_eop,              // Line closes a packet
	output logic [TAG_W-1:0]       o_line_tag               // Logical port of the line
);

	localparam int PW     = $clog2(DEPTH);
	localparam int CW     = PW + 1;
	localparam int SIDE_W = TAG_W + 2;

	typedef enum {ST_POLL, ST_SKIP} poll_state_t;

	// ********************************************
	// Decoding helpers
	// ********************************************
	// Address bits that count for a given partition code
	function automatic logic [2:0] part_mask(input logic [1:0] pc);
		case (pc)
			PART_1:  part_mask = 3'h0;
			PART_2:  part_mask = 3'h1;
			PART_4:  part_mask = 3'h3;
			default: part_mask = 3'h7;
		endcase
	endfunction

	// Single partition ignores the address; otherwise high bits must be zero
	function automatic logic part_ok(input logic [2:0] a, input logic [1:0] pc);
		part_ok = (pc == PART_1) || ((a & ~part_mask(pc)) == 3'h0);
	endfunction

	function automatic logic [2:0] lanes_per_write(input agg_mode_t m);
		case (m)
			AGG_32:  lanes_per_write = 3'h1;
			AGG_64:  lanes_per_write = 3'h2;
			default: lanes_per_write = 3'h4;
		endcase
	endfunction

	// First line of a partition inside the bank memory
	function automatic logic [PW-1:0] base(input logic [2:0] p, input logic [1:0] pc);
		base = PW'(int'(p) * (DEPTH >> pc));
	endfunction

	// Lowest partition that holds a whole line
	function automatic logic [2:0] first_set(input logic [NPART-1:0] v);
		first_set = 3'h0;
		for (int i = NPART - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_set = 3'(i);
			end
		end
	endfunction

	// ********************************************
	// Poller state and read selection
	// ********************************************
	wire [LINE_W-1:0]    rd_line [NUM_BANKS];
	wire [SIDE_W-1:0]    rd_side [NUM_BANKS];
	wire [NUM_BANKS-1:0] lead_v;
	wire [NUM_BANKS-1:0] any_v;
	poll_state_t         st_reg;
	logic [PORT_W-1:0]   cur_reg;
	logic [PORT_W-1:0]   cand_reg;
	logic [7:0]          cyc_reg;

	// Read only while polling an enabled lead bank that holds a line
	wire [PORT_W-1:0] nxt      = cur_reg + 2'h1;
	wire              inh_cur  = wr.bank_service_inhibit[cur_reg];
	wire              rd_go    = (st_reg == ST_POLL) && !inh_cur && lead_v[cur_reg] && any_v[cur_reg];
	wire              poll_end = cyc_reg == 8'(BURST - 1);
	wire              skip_end = cyc_reg == 8'(SKIP_IDLE - 1);

	// ********************************************
	// Banks
	// ********************************************
	for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
		logic [SIDE_W-1:0] side_mem [DEPTH];
		logic [PW-1:0]     wptr_reg [NPART];
		logic [PW-1:0]     rptr_reg [NPART];
		logic [CW-1:0]     count_reg [NPART];
		logic [1:0]        lane_reg [NPART];
		logic [NPART-1:0]  sop_reg;
		logic [NPART-1:0]  busy;

		// Write side decode
		wire agg_mode_t    agg      = i_agg_mode[b];
		wire [1:0]         pc       = i_part_code[b];
		wire [2:0]         wp       = wr.addr[b] & part_mask(pc);
		wire               addr_ok  = part_ok(wr.addr[b], pc);
		wire [CW-1:0]      size     = CW'(DEPTH >> pc);
		wire [PW-1:0]      pmask    = PW'(size - 1'b1);
		wire [2:0]         lane0    = {1'b0, lane_reg[wp]};
		wire [2:0]         lane_sum = lane0 + lanes_per_write(agg);
		wire               lead     = (agg == AGG_32) || (agg == AGG_64 && b % 2 == 0) || (b == 0);
		wire [CW-1:0]      lvl      = count_reg[wp];
		wire               room     = lvl < size;
		wire               acc      = wr.we[b] && lead && addr_ok && (|wr.byte_lane_valid[b]) && room;
		wire               close    = acc && (lane_sum == 3'(LANES) || wr.eop[b]);
		wire [PW-1:0]      waddr    = base(wp, pc) + wptr_reg[wp];

		// Read side decode
		wire [2:0]         rp       = first_set(busy);
		wire [PW-1:0]      raddr    = base(rp, pc) + rptr_reg[rp];
		wire               pop      = rd_go && (cur_reg == 2'(b));

		// Fill flag follows the address at once, no write needed
		assign wr.full[b] = i_thresh_3q[b] ? (lvl >= size - (size >> 2)) : (lvl >= size);
		assign lead_v[b]  = lead;
		assign any_v[b]   = |busy;
		assign rd_side[b] = side_mem[raddr];

		// Only committed lines count, so half-built lines are never read
		always_comb begin
			for (int i = 0; i < NPART; i++) begin
				busy[i] = count_reg[i] != '0;
			end
		end

		// Lanes land straight in memory; partner banks feed the upper lanes
		for (genvar l = 0; l < LANES; l++) begin : g_lane
			logic [LANE_W-1:0] mem [DEPTH];
			wire [2:0] off = 3'(l) - lane0;
			wire       hit = acc && (3'(l) >= lane0) && (off < lanes_per_write(agg));
			wire [1:0] src = 2'(b) + off[1:0];

			always_ff @(posedge i_clk) begin
				if (hit) begin
					mem[waddr] <= wr.data[src];
				end
			end

			assign rd_line[b][l*LANE_W +: LANE_W] = mem[raddr];
		end

		// Tag and EOP of the line come from its closing write, SOP from any of its writes
		always_ff @(posedge i_clk) begin
			if (close) begin
				side_mem[waddr] <= {sop_reg[wp] | wr.sop[b], wr.eop[b], wr.logical_port_tag[b]};
			end
		end

		// Partition pointers; changing the split while data is held scrambles them
		always_ff @(posedge i_clk or negedge i_rst_b) begin
			if (!i_rst_b) begin
				for (int i = 0; i < NPART; i++) begin
					wptr_reg[i]  <= '0;
					rptr_reg[i]  <= '0;
					count_reg[i] <= '0;
					lane_reg[i]  <= 2'h0;
				end
				sop_reg <= '0;
			end else begin
				for (int i = 0; i < NPART; i++) begin
					if (acc && wp == 3'(i)) begin
						lane_reg[i] <= close ? 2'h0 : lane_sum[1:0];
						sop_reg[i]  <= close ? 1'b0 : (sop_reg[i] | wr.sop[b]);
					end
					if (close && wp == 3'(i)) begin
						wptr_reg[i] <= (wptr_reg[i] + 1'b1) & pmask;
					end
					if (pop && rp == 3'(i)) begin
						rptr_reg[i] <= (rptr_reg[i] + 1'b1) & pmask;
					end
					count_reg[i] <= count_reg[i] + CW'(close && wp == 3'(i)) - CW'(pop && rp == 3'(i));
				end
			end
		end
	end

	// ********************************************
	// Calendar port poller
	// ********************************************
	// Port n maps to bank n; a skipped port stretches the previous poll
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_reg   <= ST_POLL;
			cur_reg  <= '0;
			cand_reg <= '0;
			cyc_reg  <= 8'h00;
		end else begin
			case (st_reg)
				ST_POLL: begin
					if (poll_end) begin
						cyc_reg <= 8'h00;
						if (!wr.bank_service_inhibit[nxt]) begin
							cur_reg <= nxt;
						end else begin
							st_reg   <= ST_SKIP;
							cand_reg <= nxt + 2'h1;
						end
					end else begin
						cyc_reg <= cyc_reg + 8'h01;
					end
				end
				ST_SKIP: begin
					if (skip_end) begin
						cyc_reg <= 8'h00;
						if (!wr.bank_service_inhibit[cand_reg]) begin
							cur_reg <= cand_reg;
							st_reg  <= ST_POLL;
						end else begin
							cand_reg <= cand_reg + 2'h1;
						end
					end else begin
						cyc_reg <= cyc_reg + 8'h01;
					end
				end
				default: begin
					st_reg <= ST_POLL;
				end
			endcase
		end
	end

	// Port tag is the poller's own register
	assign o_port_tag = cur_reg;

	// ********************************************
	// Line output
	// ********************************************
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_line_valid <= 1'b0;
			o_line_data  <= '0;
			o_line_sop   <= 1'b0;
			o_line_eop   <= 1'b0;
			o_line_tag   <= '0;
		end else begin
			o_line_valid <= rd_go;
			if (rd_go) begin
				o_line_data <= rd_line[cur_reg];
				{o_line_sop, o_line_eop, o_line_tag} <= rd_side[cur_reg];
			end
		end
	end

endmodule

`default_nettype wire

// File: tx_fabric_writer.sv
// Fabric-side writer: software loads lane data and a command over AXI4-Lite,
// and each command write issues one write cycle on the partition buffer port.
// Assumes the buffer shares i_clk, so its full flags need no synchroniser.
`default_nettype none

module tx_fabric_writer
	import tx_wport_pkg::*;
(
	input  wire logic        i_clk,     // System clock
	input  wire logic        i_rst_b,   // Async reset, active low
	tx_write_if.writer       wr,        // Fabric write port
	input  wire logic        i_awvalid, // Write address valid
	output logic             o_awready, // Write address ready
	input  wire logic [7:0]  i_awaddr,  // Write byte address
	input  wire logic        i_wvalid,  // Write data valid
	output logic             o_wready,  // Write data ready
	input  wire logic [31:0] i_wdata,   // Write data
	input  wire logic [3:0]  i_wstrb,   // Byte strobes
	output logic             o_bvalid,  // Write response valid
	input  wire logic        i_bready,  // Write response ready
	output logic [1:0]       o_bresp,   // Write response
	input  wire logic        i_arvalid, // Read address valid
	output logic             o_arready, // Read address ready
	input  wire logic [7:0]  i_araddr,  // Read byte address
	output logic             o_rvalid,  // Read data valid
	input  wire logic        i_rready,  // Read data ready
	output logic [31:0]      o_rdata,   // Read data
	output logic [1:0]       o_rresp    // Read response
);

	logic [31:0]          data_reg [NUM_BANKS];
	logic [31:0]          cmd_reg;
	logic [NUM_BANKS-1:0] inhibit_reg;
	logic [NUM_BANKS-1:0] status_reg;
	logic                 fire_reg;
	logic [7:0]           awaddr_reg;
	logic [31:0]          wdata_reg;
	logic [3:0]           wstrb_reg;

	// Merge strobed bytes into a stored word
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
		merge = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				merge[i*8 +: 8] = n[i*8 +: 8];
			end
		end
	endfunction

	// ********************************************
	// Write decode
	// ********************************************
	wire       do_wr   = !o_awready && !o_wready && !o_bvalid;
	wire       wr_data = awaddr_reg < OFS_CMD && awaddr_reg[1:0] == 2'h0;
	wire       wr_cmd  = awaddr_reg == OFS_CMD;
	wire       wr_inh  = awaddr_reg == OFS_INHIBIT;
	wire [1:0] wr_idx  = awaddr_reg[3:2];
	wire [1:0] bank    = cmd_reg[CMD_BANK_LSB +: 2];

	// Read decode; status shows the fill flags of the addressed partitions
	wire       rd_data = i_araddr < OFS_CMD && i_araddr[1:0] == 2'h0;
	wire       rd_hit  = rd_data || i_araddr == OFS_CMD || i_araddr == OFS_INHIBIT || i_araddr == OFS_STATUS;
	wire [31:0] rd_val = rd_data ? data_reg[i_araddr[3:2]] :
		(i_araddr == OFS_CMD) ? cmd_reg :
		(i_araddr == OFS_INHIBIT) ? 32'(inhibit_reg) :
		(i_araddr == OFS_STATUS) ? 32'(status_reg) : 32'h0000_0000;

	// ********************************************
	// AXI4-Lite write channel
	// ********************************************
	// Address and data may come in either order; response once both are held
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_awready  <= 1'b1;
			o_wready   <= 1'b1;
			o_bvalid   <= 1'b0;
			o_bresp    <= RESP_OKAY;
			awaddr_reg <= 8'h00;
			wdata_reg  <= 32'h0000_0000;
			wstrb_reg  <= 4'h0;
		end else begin
			if (i_awvalid && o_awready) begin
				awaddr_reg <= i_awaddr;
				o_awready  <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				wdata_reg <= i_wdata;
				wstrb_reg <= i_wstrb;
				o_wready  <= 1'b0;
			end
			if (do_wr) begin
				o_bvalid <= 1'b1;
				o_bresp  <= (wr_data || wr_cmd || wr_inh) ? RESP_OKAY : RESP_SLVERR;
			end
			if (o_bvalid && i_bready) begin
				o_bvalid  <= 1'b0;
				o_awready <= 1'b1;
				o_wready  <= 1'b1;
			end
		end
	end

	// Register file; a command write fires one port cycle
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int k = 0; k < NUM_BANKS; k++) begin
				data_reg[k] <= 32'h0000_0000;
			end
			cmd_reg     <= 32'h0000_0000;
			inhibit_reg <= '0;
			fire_reg    <= 1'b0;
		end else begin
			fire_reg <= do_wr && wr_cmd;
			if (do_wr && wr_data) begin
				data_reg[wr_idx] <= merge(data_reg[wr_idx], wdata_reg, wstrb_reg);
			end
			if (do_wr && wr_cmd) begin
				cmd_reg <= merge(cmd_reg, wdata_reg, wstrb_reg);
			end
			if (do_wr && wr_inh) begin
				inhibit_reg <= wdata_reg[NUM_BANKS-1:0];
			end
		end
	end

	// ********************************************
	// AXI4-Lite read channel
	// ********************************************
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_arready <= 1'b1;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h0000_0000;
			o_rresp   <= RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b1;
			o_rdata   <= rd_val;
			o_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (o_rvalid && i_rready) begin
			o_rvalid  <= 1'b0;
			o_arready <= 1'b1;
		end
	end

	// ********************************************
	// Buffer port drive
	// ********************************************
	// Address and tag are held between commands so the fill flag stays meaningful
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int k = 0; k < NUM_BANKS; k++) begin
				wr.addr[k]             <= '0;
				wr.data[k]             <= '0;
				wr.byte_lane_valid[k]  <= '0;
				wr.logical_port_tag[k] <= '0;
			end
			wr.we                   <= '0;
			wr.sop                  <= '0;
			wr.eop                  <= '0;
			wr.bank_service_inhibit <= '0;
			status_reg              <= '0;
		end else begin
			for (int k = 0; k < NUM_BANKS; k++) begin
				wr.addr[k]             <= cmd_reg[CMD_ADDR_LSB +: ADDR_W];
				wr.data[k]             <= data_reg[k];
				wr.byte_lane_valid[k]  <= cmd_reg[CMD_BV_LSB +: BV_W];
				wr.logical_port_tag[k] <= cmd_reg[CMD_TAG_LSB +: TAG_W];
				wr.we[k]               <= fire_reg && bank == 2'(k);
				wr.sop[k]              <= cmd_reg[CMD_SOP_BIT];
				wr.eop[k]              <= cmd_reg[CMD_EOP_BIT];
			end
			wr.bank_service_inhibit <= inhibit_reg;
			status_reg              <= wr.full;
		end
	end

endmodule

`default_nettype wire

// File: tx_wport_sva.sv
// Checker: poller timing and write-port strobes of the partition buffer.
// Assumes it sits beside the write interface in the bench, on the one clock.
`default_nettype none
module tx_wport_sva
	import tx_wport_pkg::*;
#(
	parameter int BURST = BURST_CYCLES // Poll length per port
) (
	input wire logic                 i_clk,                       // Clock
	input wire logic                 i_rst_b,                     // Reset, active low
	input wire logic [NUM_BANKS-1:0] we,                          // Write strobes
	input wire logic [BV_W-1:0]      byte_lane_valid [NUM_BANKS], // Lane valids
	input wire logic [NUM_BANKS-1:0] bank_service_inhibit,        // Bank inhibits
	input wire logic [PORT_W-1:0]    o_port_tag,                  // Polled port
	input wire logic                 o_line_valid                 // Line read
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0]           hold_reg;
	logic [4:0]           age_reg;
	logic [PORT_W-1:0]    tag_reg;
	logic [NUM_BANKS-1:0] inh_reg;
	logic [NUM_BANKS-1:0] wrote_reg;
	wire logic            moved;
	wire logic            settled;
	wire logic [1:0]      step;
	// Poll length count; the age keeps timing checks off while inhibits settle
	assign moved   = o_port_tag != tag_reg;
	assign settled = age_reg == 5'h1f;
	assign step    = o_port_tag - tag_reg - 2'h1;
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			hold_reg  <= '0;
			age_reg   <= '0;
			tag_reg   <= '0;
			inh_reg   <= '0;
			wrote_reg <= '0;
		end else begin
			hold_reg <= moved ? 6'h01 : hold_reg + 6'h01;
			age_reg  <= (bank_service_inhibit != inh_reg) ? 5'h00 : age_reg + 5'(!settled);
			tag_reg  <= o_port_tag;
			inh_reg  <= bank_service_inhibit;
			for (int b = 0; b < NUM_BANKS; b++)
				if (we[b] && byte_lane_valid[b] != '0) wrote_reg[b] <= 1'b1;
		end
	end
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);
	sequence idle_slot;
		settled && !moved && hold_reg >= BURST;
	endsequence
	// A poll is the burst plus two idle cycles per skipped port
	AST_POLL_LEN: assert property (settled && moved |-> hold_reg == BURST + SKIP_IDLE * step)
		else $error("poll length wrong");
	AST_POLL_ORDER: assert property (settled && moved && bank_service_inhibit == '0 |-> step == 2'h0)
		else $error("poll order wrong");
	AST_SKIP_TARGET: assert property (settled && moved |-> !bank_service_inhibit[o_port_tag])
		else $error("inhibited port polled");
	AST_IDLE_NO_READ: assert property (idle_slot |=> !o_line_valid)
		else $error("read in idle cycle");
	AST_NO_READ_INHIBITED: assert property (settled && o_line_valid |-> !inh_reg[tag_reg])
		else $error("inhibited bank read");
	AST_LINE_AFTER_WRITE: assert property (o_line_valid |-> wrote_reg[tag_reg])
		else $error("line read never written");
	AST_WE_ONE_BANK: assert property ($onehot0(we))
		else $error("two banks strobed");
	AST_WE_PULSE: assert property (we != '0 |=> we == '0)
		else $error("strobe too long");
	cover property (settled && moved && step != 2'h0);
endmodule
`default_nettype wire

// File: spi4_tx_partition_write_port_bench.sv
// Bench: writer and buffer joined by the write interface, driven over AXI4-Lite.
// Assumes the package constants and one 50 MHz clock for all parts.
`default_nettype none
module spi4_tx_partition_write_port_bench;
	import tx_wport_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [127:0] d; logic [127:0] m; logic [9:0] c;} exp_t;
	localparam int BURST = BURST_CYCLES;
	logic i_clk, i_rst_b, awv, wv, bre, arv, rre, awr, wrd, bvl, arr, rvl, lv, ls, le;
	logic [7:0] awa, ara, lt;
	logic [31:0] wd, rd, r;
	logic [1:0] brs, rrs, tag;
	logic [127:0] ld;
	agg_mode_t agg [NUM_BANKS];
	logic [1:0] pc [NUM_BANKS];
	logic [3:0] th;
	exp_t q[$], hq[$], mx;
	int n_errors, n_checks;
	int seed = 32'hed5e;
	tx_write_if wi ();
	tx_fabric_writer i_tx_fabric_writer (.i_clk(i_clk), .i_rst_b(i_rst_b), .wr(wi.writer), .i_awvalid(awv),
		.o_awready(awr), .i_awaddr(awa), .i_wvalid(wv), .o_wready(wrd), .i_wdata(wd), .i_wstrb(4'hf),
		.o_bvalid(bvl), .i_bready(bre), .o_bresp(brs), .i_arvalid(arv), .o_arready(arr), .i_araddr(ara),
		.o_rvalid(rvl), .i_rready(rre), .o_rdata(rd), .o_rresp(rrs));
	tx_partition_buffer #(.DEPTH(16), .BURST(BURST)) i_tx_partition_buffer (.i_clk(i_clk),
		.i_rst_b(i_rst_b), .wr(wi.buffer), .i_agg_mode(agg), .i_part_code(pc), .i_thresh_3q(th),
		.o_port_tag(tag), .o_line_valid(lv), .o_line_data(ld), .o_line_sop(ls), .o_line_eop(le), .o_line_tag(lt));
	tx_wport_sva #(.BURST(BURST)) i_tx_wport_sva (.i_clk(i_clk), .i_rst_b(i_rst_b), .we(wi.we),
		.byte_lane_valid(wi.byte_lane_valid), .bank_service_inhibit(wi.bank_service_inhibit),
		.o_port_tag(tag), .o_line_valid(lv));
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic results;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Address and data are offered together and each is dropped once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic pa, pw;
		@(posedge i_clk);
		awv <= 1'b1;
		wv  <= 1'b1;
		awa <= a;
		wd  <= d;
		bre <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		while (pa || pw) begin
			@(posedge i_clk);
			if (pa && awr === 1'b1) begin
				awv <= 1'b0;
				pa = 1'b0;
			end
			if (pw && wrd === 1'b1) begin
				wv <= 1'b0;
				pw = 1'b0;
			end
		end
		while (bvl !== 1'b1) @(posedge i_clk);
		bre <= 1'b0;
		chk("bresp", er, brs);
	endtask
	task automatic axr(input logic [7:0] a, input logic [1:0] er);
		@(posedge i_clk);
		arv <= 1'b1;
		ara <= a;
		rre <= 1'b1;
		do @(posedge i_clk); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge i_clk); while (rvl !== 1'b1);
		rre <= 1'b0;
		r = rd;
		chk("rresp", er, rrs);
	endtask
	task automatic put(input int b, input logic [2:0] a, input logic [31:0] d, input logic [15:0] v,
		input logic s, input logic e, input logic [7:0] t);
		axw(OFS_DATA0 + 8'(4 * b), d, RESP_OKAY);
		axw(OFS_CMD, {1'b0, 2'(b), e, s, a, t, v}, RESP_OKAY);
	endtask
	// One line of n writes; dst 1 expects it now, 2 holds it back, 0 drops it
	task automatic line(input int b, input logic [2:0] a, input int n, input logic s, input logic e, input int dst);
		exp_t x;
		int w;
		logic [7:0] t;
		w = (agg[b] == AGG_128) ? 4 : (agg[b] == AGG_64) ? 2 : 1;
		t = 8'($random(seed));
		x.d = '0;
		x.m = '0;
		x.c = {s, e, t};
		for (int i = 0; i < n; i++) begin
			r = $random(seed);
			for (int k = 1; k < w; k++) begin
				axw(OFS_DATA0 + 8'(4 * (b + k)), ~r + 32'(k), RESP_OKAY);
				x.d[(i * w + k) * 32 +: 32] = ~r + 32'(k);
			end
			x.d[i * 32 * w +: 32] = r;
			x.m = x.m | (((128'h1 << (32 * w)) - 128'h1) << (32 * w * i));
			put(b, (pc[b] == PART_1) ? 3'($random(seed)) : a, r, 16'($random(seed)) | 16'h0001,
				s && i == 0, e && i == n - 1, t);
		end
		if (dst == 1) q.push_back(x);
		if (dst == 2) hq.push_back(x);
	endtask
	// Lines leave the buffer in the order they were closed
	always @(posedge i_clk) begin
		if (lv === 1'b1) begin
			if (q.size() == 0)
				chk("unexpected line", 0, 1);
			else begin
				mx = q.pop_front();
				chk("line data", mx.d, ld & mx.m);
				chk("line ctl", mx.c, {ls, le, lt});
			end
		end
	end
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	initial begin
		repeat (20000) @(posedge i_clk);
		n_errors++;
		results();
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		{i_rst_b, awv, wv, bre, arv, rre, awa, ara, wd} = '0;
		agg = '{AGG_32, AGG_32, AGG_64, AGG_64};
		pc  = '{PART_4, PART_1, PART_2, PART_2};
		th  = 4'h1;
		repeat (2) @(posedge i_clk);
		i_rst_b <= 1'b1;
		axw(8'h40, 32'h0000_0000, RESP_SLVERR);
		axw(OFS_STATUS, 32'hffff_ffff, RESP_SLVERR);
		axr(8'h44, RESP_SLVERR);
		line(1, 0, 4, 1'b1, 1'b0, 1);
		line(1, 0, 2, 1'b0, 1'b1, 1);
		line(2, 1, 2, 1'b1, 1'b1, 1);
		put(1, 0, 32'h1234_5678, 16'h0000, 1'b1, 1'b1, 8'h11);
		put(0, 5, 32'h1234_5678, 16'hffff, 1'b1, 1'b1, 8'h22);
		line(0, 3, 1, 1'b1, 1'b1, 1);
		repeat (40) @(posedge i_clk);
		axw(OFS_INHIBIT, 32'h0000_0001, RESP_OKAY);
		for (int i = 0; i < 5; i++) begin
			line(0, 3, 1, 1'b1, 1'b1, (i < 4) ? 2 : 0);
			th <= {3'h0, i != 2};
			repeat (4) @(posedge i_clk);
			axr(OFS_STATUS, RESP_OKAY);
			chk("full flag", i >= ((i == 2) ? 3 : 2), r[0]);
		end
		put(0, 2, 32'h0000_0000, 16'h0000, 1'b0, 1'b0, 8'h00);
		repeat (4) @(posedge i_clk);
		axr(OFS_STATUS, RESP_OKAY);
		chk("full flag", 0, r[0]);
		repeat (60) @(posedge i_clk);
		foreach (hq[i]) q.push_back(hq[i]);
		axw(OFS_INHIBIT, 32'h0000_0000, RESP_OKAY);
		repeat (80) @(posedge i_clk);
		chk("pending lines", 0, q.size());
		// All banks empty now, so the split can change without stranding lines
		agg <= '{AGG_128, AGG_128, AGG_128, AGG_128};
		pc  <= '{PART_1, PART_1, PART_1, PART_1};
		repeat (2) @(posedge i_clk);
		line(0, 0, 1, 1'b1, 1'b1, 1);
		repeat (40) @(posedge i_clk);
		chk("pending lines", 0, q.size());
		results();
	end
endmodule
`default_nettype wire
